/* File: rtl/low_power_mode_and_reset_ctrl.sv */
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module low_power_mode_and_reset_ctrl
    import pwr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic radio_sleeping,
    input wire logic core_wfi,
    input wire logic deep_sleep_flag,
    input wire logic supply_ok,
    input wire logic regulator_ok,
    input wire logic wdg_reset,
    input wire logic core_lockup,
    input wire logic debugger_on,
    input wire logic sys_reset_request,
    input wire logic rwt_radio_wake,
    input wire logic rwt_host_wake,
    input wire logic rtc_wake,
    input wire logic ser_wake,
    input wire logic [GPIO_N-1:0] gpio_wake,
    input wire logic ext_reset_pin_n_in,
    output logic ext_reset_pin_n_out,
    output logic ext_reset_pin_n_oe,
    output pwr_ctl_type pwr_ctl,
    output ls_run_type ls_run,
    output logic [GPIO_N-1:0] io_hold,
    output logic [GPIO_N-1:0] io_pull_keep,
    output logic off_domain_reset_n,
    output logic power_on_reset_n,
    output logic system_reset_n,
    output logic [1:0] pwr_mode
);

    // decode a register offset from the low address bits
    function automatic logic is_reg(input logic [31:0] a,
                                    input logic [11:0] ofs);
        is_reg = (a[11:0] == ofs);
    endfunction : is_reg

    pwr_state_type state_q;
    logic [31:0] ctrl_q;
    logic [31:0] wake_en_q;
    logic [WAKE_W-1:0] cause_q;
    logic [GPIO_N-1:0] pull_q;
    logic [GPIO_N-1:0] hold_q;
    logic wr_q;
    logic [11:0] wa_q;
    logic rd_q;
    logic [31:0] rdata_q;
    logic [7:0] pulse_q;
    logic [2:0] por_q;
    logic [1:0] rel_q;
    logic sw_req_q;

    // three-stage synchronisers for pin and foreign inputs
    localparam int SN = 9 + GPIO_N;
    logic [SN-1:0] s1_q, s2_q, s3_q;
    logic [SN-1:0] raw;
    logic [SN-1:0] sy_q;
    assign raw = {ext_reset_pin_n_in, supply_ok, regulator_ok, wdg_reset,
                  rwt_radio_wake, rwt_host_wake, rtc_wake, ser_wake,
                  core_lockup, gpio_wake};

    // chain per bit; accept a change when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SN; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    sy_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        sy_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    logic pin_n, sup_ok, reg_ok, wdg_s, lock_s;
    logic [WAKE_W-1:0] wake_ev;
    assign pin_n = sy_q[SN-1];
    assign sup_ok = sy_q[SN-2];
    assign reg_ok = sy_q[SN-3];
    assign wdg_s = sy_q[SN-4];
    assign lock_s = sy_q[GPIO_N];
    // watchdog is not a wake source, it resets instead
    assign wake_ev = {|sy_q[GPIO_N-1:0], sy_q[GPIO_N+1], sy_q[GPIO_N+2],
                      sy_q[GPIO_N+3], sy_q[GPIO_N+4]};

    logic wake_any;
    assign wake_any = |(wake_ev & wake_en_q[WAKE_W-1:0]);

    // low power entry condition common to both modes
    logic lp_entry;
    assign lp_entry = radio_sleeping && core_wfi && deep_sleep_flag &&
                      !wake_any && ctrl_q[HOLD_SEL_BIT];

    // ahb-lite slave, zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    logic acc;
    assign acc = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wa_q <= 12'h000;
        end else begin
            wr_q <= acc && hwrite;
            rd_q <= acc && !hwrite;
            wa_q <= haddr[11:0];
        end
    end

    // read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            if (is_reg(haddr, CTRL_OFS)) begin
                rdata_q <= ctrl_q;
            end else if (is_reg(haddr, WAKE_EN_OFS)) begin
                rdata_q <= wake_en_q;
            end else if (is_reg(haddr, STATUS_OFS)) begin
                rdata_q <= {27'h0000000, cause_q};
            end else if (is_reg(haddr, PULL_OFS)) begin
                rdata_q <= {12'h000, pull_q};
            end else if (is_reg(haddr, HOLD_OFS)) begin
                rdata_q <= {12'h000, hold_q};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    // config registers; power controller survives system reset
    logic [31:0] wa32;
    assign wa32 = {20'h00000, wa_q};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RST;
            wake_en_q <= WAKE_EN_RST;
            pull_q <= '0;
            hold_q <= '0;
        end else if (!power_on_reset_n) begin
            ctrl_q <= CTRL_RST; // power-on clears the controller
            wake_en_q <= WAKE_EN_RST;
            pull_q <= '0;
            hold_q <= '0;
        end else if (wr_q) begin
            if (is_reg(wa32, CTRL_OFS)) begin
                ctrl_q <= hwdata;
            end
            if (is_reg(wa32, WAKE_EN_OFS)) begin
                wake_en_q <= hwdata;
            end
            if (is_reg(wa32, PULL_OFS)) begin
                pull_q <= hwdata[GPIO_N-1:0];
            end
            if (is_reg(wa32, HOLD_OFS)) begin
                hold_q <= hwdata[GPIO_N-1:0];
            end
        end else if (ctrl_q[SW_RST_BIT]) begin
            ctrl_q[SW_RST_BIT] <= 1'b0; // self-clearing request
        end
    end

    // wake cause: captured on leaving stop, cleared by status write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_q <= '0;
        end else if (!power_on_reset_n) begin
            cause_q <= '0;
        end else if (state_q == ST_STOP && wake_any) begin
            cause_q <= wake_ev & wake_en_q[WAKE_W-1:0];
        end else if (wr_q && is_reg(wa32, STATUS_OFS)) begin
            cause_q <= cause_q & ~hwdata[WAKE_W-1:0];
        end
    end

    // mode sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (lp_entry && !ctrl_q[LPS_BIT]) begin
                        state_q <= ST_STOP;
                    end else if (lp_entry && ctrl_q[LPS_BIT]) begin
                        state_q <= ST_SHUT;
                    end
                end
                ST_STOP: begin
                    if (wake_any || !pin_n || wdg_s) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_SHUT: begin
                    if (!pin_n) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (pin_n) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    logic in_stop, in_shut, shut_exit;
    assign in_stop = (state_q == ST_STOP);
    assign in_shut = (state_q == ST_SHUT);
    assign shut_exit = in_shut && !pin_n;
    assign pwr_mode = state_q;

    // power, clock and retention controls
    logic ls_on;
    assign ls_on = in_stop && ctrl_q[LS_ON_BIT];
    always_comb begin
        pwr_ctl.sys_clk_en = !(in_stop || in_shut);
        pwr_ctl.bus_clk_en = !(in_stop || in_shut);
        pwr_ctl.main_reg_en = !(in_stop || in_shut);
        pwr_ctl.lp_reg_en = !in_shut;
        pwr_ctl.lp_reg_low = in_stop;
        pwr_ctl.switch_dom_en = !(in_stop || in_shut);
        pwr_ctl.ram0_ret = !in_shut;
        pwr_ctl.ram1_ret = !in_shut &&
                           (!in_stop || ctrl_q[RAM1_RET_BIT]);
        pwr_ctl.ls_xtal_en = ls_on && ctrl_q[LS_SRC_BIT];
        pwr_ctl.ls_rc_en = ls_on && !ctrl_q[LS_SRC_BIT];
        pwr_ctl.bor_en = !in_shut || ctrl_q[BOR_SD_BIT];
    end

    // low-speed peripherals and dedicated clock outputs in stop
    always_comb begin
        ls_run.rtc_run = ls_on && ctrl_q[RTC_EN_BIT];
        ls_run.wdg_run = ls_on && ctrl_q[WDG_EN_BIT];
        ls_run.ser_run = ls_on && ctrl_q[SER_EN_BIT];
        ls_run.rwt_run = ls_on && ctrl_q[RWT_EN_BIT];
        ls_run.lsco_keep = ls_on && ctrl_q[LSCO_BIT];
        ls_run.rtco_keep = ls_run.rtc_run && ctrl_q[RTCO_BIT];
    end

    // io retention in stop, pulls only in shutdown
    assign io_hold = in_stop ? hold_q : '0;
    assign io_pull_keep = in_shut ? pull_q : '0;
    assign off_domain_reset_n = !(in_stop || state_q == ST_WAKE);

    // power-on reset source, also raised by shutdown exit
    logic por_src;
    assign por_src = !sup_ok || !reg_ok || shut_exit;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            por_q <= 3'b000;
        end else begin
            por_q <= por_src ? 3'b000 : {por_q[1:0], 1'b1};
        end
    end
    assign power_on_reset_n = por_q[2];

    // internal sources; lockup ignored with debugger
    logic int_src;
    assign sw_req_q = ctrl_q[SW_RST_BIT] || sys_reset_request;
    assign int_src = !power_on_reset_n || wdg_s ||
                     (lock_s && !debugger_on) || sw_req_q;

    // stretch internal resets; pad reset lasts while pin is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_q <= RST_PULSE_CNT;
        end else if (int_src) begin
            pulse_q <= RST_PULSE_CNT;
        end else if (pulse_q != 8'h00) begin
            pulse_q <= pulse_q - 8'h01;
        end
    end

    // own pin drive still in the synchroniser; hold reset, no echo loop
    logic [4:0] blank_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blank_q <= 5'h1F;
        end else begin
            blank_q <= {blank_q[3:0], ext_reset_pin_n_oe};
        end
    end

    // synchronous release of the merged system reset
    logic sys_rst_act;
    assign sys_rst_act = (pulse_q != 8'h00) || (blank_q != 5'h00) ||
                         !pin_n;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rel_q <= 2'b00;
        end else begin
            rel_q <= sys_rst_act ? 2'b00 : {rel_q[0], 1'b1};
        end
    end
    assign system_reset_n = rel_q[1];

    // pin pulled low during an internal pulse; a pad reset is low already
    assign ext_reset_pin_n_out = 1'b0;
    assign ext_reset_pin_n_oe = (pulse_q != 8'h00);

    // reset held low for at least eight cycles, starting two cycles after a source appears
    sequence rst_held_s;
        !system_reset_n [*8];
    endsequence
    rst_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(int_src) |-> ##2 rst_held_s)
        else $error("reset pulse too short");
    stop_clk_a: assert property (@(posedge hclk) disable iff (!hresetn)
        in_stop |-> !pwr_ctl.sys_clk_en && !pwr_ctl.bus_clk_en)
        else $error("clock running in stop");
    stop_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(in_stop) |-> $past(lp_entry) && !ctrl_q[LPS_BIT])
        else $error("bad stop entry");
    shut_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(in_shut) |-> $past(lp_entry) && ctrl_q[LPS_BIT])
        else $error("bad shutdown entry");
    shut_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        in_shut && pin_n |=> in_shut)
        else $error("shutdown left without pin");
    shut_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        in_shut |-> !pwr_ctl.ls_rc_en && !pwr_ctl.ls_xtal_en
        && !pwr_ctl.main_reg_en)
        else $error("shutdown power left on");
    lock_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
        debugger_on && lock_s && !sw_req_q && !wdg_s && power_on_reset_n
        && pulse_q == 8'h00 && pin_n |=> pulse_q == 8'h00)
        else $error("lockup reset not masked");
    pin_ind_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(int_src) |=> ext_reset_pin_n_oe && !ext_reset_pin_n_out)
        else $error("reset not shown on pin");
    ls_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ls_run.rtc_run |-> pwr_ctl.ls_xtal_en || pwr_ctl.ls_rc_en)
        else $error("rtc runs without clock");
    pad_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !pin_n |=> !system_reset_n)
        else $error("pad reset not applied");
    stop_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
        in_stop && wake_any |=> state_q == ST_WAKE && cause_q != '0)
        else $error("wake not taken or cause lost");
    shut_pull_a: assert property (@(posedge hclk) disable iff (!hresetn)
        in_shut |-> io_pull_keep == pull_q && io_hold == '0)
        else $error("io state wrong in shutdown");
    por_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !power_on_reset_n |=> ctrl_q == CTRL_RST && cause_q == '0)
        else $error("power-on reset left state");

endmodule : low_power_mode_and_reset_ctrl

/* File: rtl/pwr_pkg.sv */
package pwr_pkg;

    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] WAKE_EN_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;
    localparam logic [11:0] PULL_OFS = 12'h00C;
    localparam logic [11:0] HOLD_OFS = 12'h010;

    // control field positions
    localparam int LPS_BIT = 0;
    localparam int HOLD_SEL_BIT = 1;
    localparam int RAM1_RET_BIT = 2;
    localparam int LS_ON_BIT = 3;
    localparam int LS_SRC_BIT = 4;
    localparam int BOR_SD_BIT = 5;
    localparam int RTC_EN_BIT = 6;
    localparam int WDG_EN_BIT = 7;
    localparam int SER_EN_BIT = 8;
    localparam int RWT_EN_BIT = 9;
    localparam int LSCO_BIT = 10;
    localparam int RTCO_BIT = 11;
    localparam int SW_RST_BIT = 12;

    // wake cause bit positions (status and enable)
    localparam int WK_RADIO = 0;
    localparam int WK_HOST = 1;
    localparam int WK_RTC = 2;
    localparam int WK_SER = 3;
    localparam int WK_GPIO = 4;
    localparam int WAKE_W = 5;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] WAKE_EN_RST = 32'h0000_001F;

    // io counts
    localparam int GPIO_N = 20;

    // timing
    localparam int CLK_MHZ = 10;
    localparam int RST_PULSE_US = 20;
    localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_MHZ;
    localparam logic [7:0] RST_PULSE_CNT = 8'(RST_PULSE_CYC);

    // power states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_STOP = 2'b01,
        ST_SHUT = 2'b10,
        ST_WAKE = 2'b11
    } pwr_state_type;

    // power-domain controls sent to analog and clock tree
    typedef struct packed {
        logic sys_clk_en;
        logic bus_clk_en;
        logic main_reg_en;
        logic lp_reg_en;
        logic lp_reg_low;
        logic switch_dom_en;
        logic ram0_ret;
        logic ram1_ret;
        logic ls_xtal_en;
        logic ls_rc_en;
        logic bor_en;
    } pwr_ctl_type;

    // low-speed peripheral run enables
    typedef struct packed {
        logic rtc_run;
        logic wdg_run;
        logic ser_run;
        logic rwt_run;
        logic lsco_keep;
        logic rtco_keep;
    } ls_run_type;

endpackage : pwr_pkg

/* File: test/core_radio_model.sv */
`timescale 1ns/1ns
// core, radio timer and wake peripherals facing the controller
module core_radio_model
    import pwr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sleep_cmd,
    input wire logic [WAKE_W-1:0] wake_cmd,
    input wire logic sreq_cmd,
    input wire logic [1:0] pwr_mode,
    input wire logic system_reset_n,
    output logic radio_sleeping,
    output logic core_wfi,
    output logic deep_sleep_flag,
    output logic sys_reset_request,
    output logic rwt_radio_wake,
    output logic rwt_host_wake,
    output logic rtc_wake,
    output logic ser_wake,
    output logic [GPIO_N-1:0] gpio_wake
);
    logic asleep_q;
    logic [WAKE_W-1:0] src_q;

    // core sleeps on command, restarts on wake or system reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            asleep_q <= 1'b0;
        end else if (pwr_mode == ST_WAKE || !system_reset_n) begin
            asleep_q <= 1'b0;
        end else if (sleep_cmd) begin
            asleep_q <= 1'b1;
        end
    end

    // wake levels held until the controller answers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= '0;
        end else if (pwr_mode == ST_WAKE || !system_reset_n) begin
            src_q <= '0;
        end else begin
            src_q <= src_q | wake_cmd;
        end
    end

    // deep wait with radio idle; firmware reset request
    assign radio_sleeping = asleep_q;
    assign core_wfi = asleep_q;
    assign deep_sleep_flag = asleep_q;
    assign sys_reset_request = sreq_cmd;
    assign rwt_radio_wake = src_q[WK_RADIO];
    assign rwt_host_wake = src_q[WK_HOST];
    assign rtc_wake = src_q[WK_RTC];
    assign ser_wake = src_q[WK_SER];
    assign gpio_wake = {src_q[WK_GPIO], {(GPIO_N-1){1'b0}}};
endmodule : core_radio_model

/* File: test/low_power_mode_and_reset_ctrl_tb.sv */
`timescale 1ns/1ns
module low_power_mode_and_reset_ctrl_tb
    import pwr_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, supply_ok, regulator_ok, wdg_reset;
    logic core_lockup, debugger_on, pin_drv, sleep_cmd, sreq_cmd, hready;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, pwr_mode;
    logic [2:0] hsize;
    logic [WAKE_W-1:0] wake_cmd;
    logic radio_sleeping, core_wfi, deep_sleep_flag, sys_reset_request;
    logic rwt_radio_wake, rwt_host_wake, rtc_wake, ser_wake;
    logic [GPIO_N-1:0] gpio_wake, io_hold, io_pull_keep;
    logic pin_in, pin_out, pin_oe, off_domain_reset_n;
    logic power_on_reset_n, system_reset_n;
    pwr_ctl_type pwr_ctl;
    ls_run_type ls_run;
    int mismatches, n_compared, n;

    // reset pin: pulled up by the board, pulled low by either side
    assign pin_in = pin_oe ? (pin_out & pin_drv) : pin_drv;
    always #50 hclk = ~hclk;

    low_power_mode_and_reset_ctrl u_low_power_mode_and_reset_ctrl (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout(hready), .hresp(), .radio_sleeping,
        .core_wfi, .deep_sleep_flag, .supply_ok, .regulator_ok, .wdg_reset,
        .core_lockup, .debugger_on, .sys_reset_request, .rwt_radio_wake,
        .rwt_host_wake, .rtc_wake, .ser_wake, .gpio_wake,
        .ext_reset_pin_n_in(pin_in), .ext_reset_pin_n_out(pin_out),
        .ext_reset_pin_n_oe(pin_oe), .pwr_ctl, .ls_run, .io_hold,
        .io_pull_keep, .off_domain_reset_n, .power_on_reset_n,
        .system_reset_n, .pwr_mode);

    core_radio_model u_core_radio_model (
        .hclk, .hresetn, .sleep_cmd, .wake_cmd, .sreq_cmd, .pwr_mode,
        .system_reset_n, .radio_sleeping, .core_wfi, .deep_sleep_flag,
        .sys_reset_request, .rwt_radio_wake, .rwt_host_wake, .rtc_wake,
        .ser_wake, .gpio_wake);

    task finish_test;
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task check(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask : check

    task tick(input int c);
        repeat (c) @(posedge hclk);
    endtask : tick

    task wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            check(32'h0, 32'h1, "bus hang");
            finish_test;
        end
    endtask : wait_ready

    // one single word transfer: address phase, then data phase
    task ahb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h00000, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
    endtask : ahb

    task rd_chk(input logic [11:0] ofs, input logic [31:0] e, input string s);
        ahb(1'b0, ofs, 32'h0);
        check(rd, e, s);
    endtask : rd_chk

    function automatic logic [1:0] cur(input int sel);
        case (sel)
            0: return pwr_mode;
            1: return {1'b0, system_reset_n};
            default: return {1'b0, power_on_reset_n};
        endcase
    endfunction : cur

    task wait_sig(input int sel, input logic [1:0] v);
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (cur(sel) !== v && k < 1000);
        if (cur(sel) !== v) begin
            check(32'(cur(sel)), 32'(v), "wait timeout");
            finish_test;
        end
    endtask : wait_sig

    task sleep_now;
        sleep_cmd <= 1'b1;
        @(posedge hclk);
        sleep_cmd <= 1'b0;
    endtask : sleep_now

    task wake_pulse(input int w);
        @(posedge hclk);
        wake_cmd <= WAKE_W'(1 << w);
        @(posedge hclk);
        wake_cmd <= '0;
    endtask : wake_pulse

    // main sequence
    initial begin
        {hresetn, hsel, hwrite, wdg_reset, core_lockup, debugger_on} = '0;
        {sleep_cmd, sreq_cmd, haddr, hwdata, htrans, wake_cmd} = '0;
        {supply_ok, regulator_ok, pin_drv} = 3'h7;
        hsize = 3'h2;
        mismatches = 0;
        n_compared = 0;
        tick(16);
        hresetn <= 1'b1;
        wait_sig(2, 2'h1);
        wait_sig(1, 2'h1);
        rd_chk(CTRL_OFS, CTRL_RST, "ctrl reset");
        rd_chk(WAKE_EN_OFS, WAKE_EN_RST, "wake enable reset");
        rd_chk(STATUS_OFS, 32'h0, "status reset");
        ahb(1'b1, 12'h020, 32'hFFFF_FFFF);
        rd_chk(12'h020, 32'h0, "unmapped");
        ahb(1'b1, HOLD_OFS, 32'h000A_5A5A);
        ahb(1'b1, PULL_OFS, 32'h0005_A5A5);
        ahb(1'b1, CTRL_OFS, 32'h0000_075A);
        rd_chk(HOLD_OFS, 32'h000A_5A5A, "hold mask");
        // watchdog, lockup and both software requests stretched and shown on the pin, then the pad reset
        for (int i = 0; i < 5; i++) begin
            case (i)
                0: wdg_reset <= 1'b1;
                1: core_lockup <= 1'b1;
                2: sreq_cmd <= 1'b1;
                3: ahb(1'b1, CTRL_OFS, 32'h0000_175A);
                default: pin_drv <= 1'b0;
            endcase
            wait_sig(1, 2'h0);
            check(32'({pin_in, pin_oe}), (i < 4) ? 32'h1 : 32'h0,
                  "pin shows reset");
            tick(3);
            {wdg_reset, core_lockup, sreq_cmd, pin_drv} <= 4'h1;
            n = 0;
            while (system_reset_n !== 1'b1 && n < 1000) begin
                @(posedge hclk);
                n++;
            end
            // four cycles were spent before counting began
            if (i < 4) begin
                check(32'(n + 4 >= RST_PULSE_CYC), 32'h1, "width");
            end
            check(32'(power_on_reset_n), 32'h1, "por kept");
            rd_chk(CTRL_OFS, 32'h0000_075A, "ctrl kept");
        end
        // lockup ignored while a debugger is attached
        debugger_on <= 1'b1;
        core_lockup <= 1'b1;
        n = 0;
        repeat (20) begin
            @(posedge hclk);
            if (system_reset_n !== 1'b1) n++;
        end
        core_lockup <= 1'b0;
        tick(8);
        debugger_on <= 1'b0;
        check(32'(n), 32'h0, "lockup masked");
        // no stop entry without gpio hold
        ahb(1'b1, CTRL_OFS, 32'h0000_0758);
        sleep_now;
        tick(10);
        check(32'(pwr_mode), 32'(ST_RUN), "stop without hold");
        // stop entry and each wake cause
        for (int w = 0; w < WAKE_W; w++) begin
            ahb(1'b1, CTRL_OFS, w[0] ? 32'h0000_074E : 32'h0000_075A);
            sleep_now;
            wait_sig(0, ST_STOP);
            check(32'(pwr_ctl), w[0] ? 32'h0DB : 32'h0D5,
                  "stop power");
            check(32'(ls_run), 32'h2E, "stop ls run");
            check(32'(io_hold), 32'h000A_5A5A, "io hold");
            check(32'(off_domain_reset_n), 32'h0, "off domain");
            wake_pulse(w);
            wait_sig(0, ST_WAKE);
            wait_sig(0, ST_RUN);
            rd_chk(STATUS_OFS, 32'(1 << w), "wake cause");
            ahb(1'b1, STATUS_OFS, 32'h0000_001F);
            rd_chk(STATUS_OFS, 32'h0, "cause cleared");
        end
        // masked source leaves the device stopped
        ahb(1'b1, WAKE_EN_OFS, 32'h0000_001B);
        sleep_now;
        wait_sig(0, ST_STOP);
        wake_pulse(WK_RTC);
        tick(30);
        check(32'(pwr_mode), 32'(ST_STOP), "masked wake");
        wake_pulse(WK_GPIO);
        wait_sig(0, ST_RUN);
        rd_chk(STATUS_OFS, 32'(1 << WK_GPIO), "unmasked cause");
        ahb(1'b1, WAKE_EN_OFS, 32'h0000_001F);
        // shutdown: everything off but brown-out detection, only the pin brings it back
        ahb(1'b1, CTRL_OFS, 32'h0000_002B);
        sleep_now;
        wait_sig(0, ST_SHUT);
        check(32'({pwr_ctl.sys_clk_en, pwr_ctl.bus_clk_en, pwr_ctl.main_reg_en,
            pwr_ctl.lp_reg_en, pwr_ctl.ls_xtal_en, pwr_ctl.ls_rc_en,
            pwr_ctl.bor_en}), 32'h1, "shutdown power");
        check(32'(io_pull_keep), 32'h0005_A5A5, "pulls kept");
        wake_pulse(WK_GPIO);
        tick(30);
        check(32'(pwr_mode), 32'(ST_SHUT), "no wake in shutdown");
        pin_drv <= 1'b0;
        wait_sig(2, 2'h0);
        tick(5);
        pin_drv <= 1'b1;
        wait_sig(1, 2'h1);
        check(32'(pwr_mode), 32'(ST_RUN), "run after pin");
        rd_chk(CTRL_OFS, 32'h0, "ctrl after shutdown");
        // supply and regulator faults give power-on reset
        for (int i = 0; i < 2; i++) begin
            ahb(1'b1, CTRL_OFS, 32'h0000_0040);
            if (i == 0) supply_ok <= 1'b0;
            else regulator_ok <= 1'b0;
            wait_sig(2, 2'h0);
            tick(5);
            check(32'(system_reset_n), 32'h0, "por into system");
            {supply_ok, regulator_ok} <= 2'h3;
            wait_sig(1, 2'h1);
            rd_chk(CTRL_OFS, 32'h0, "por clears");
        end
        finish_test;
    end
endmodule : low_power_mode_and_reset_ctrl_tb
